// ===== dv/bgp_pin_model.sv
// Behavioural model of the external pins facing the port block
`timescale 1ns/1ps
module bgp_pin_model #(
   parameter int NB = 56
) (
   input  wire logic          clk,
   input  wire logic [NB-1:0] pin_out,
   input  wire logic [NB-1:0] pin_oe_n,
   input  wire logic [NB-1:0] pin_pullup_en,
   input  wire logic [NB-1:0] pin_in_buf_en,
   input  wire logic [NB-1:0] ext_val,
   input  wire logic [NB-1:0] ext_en,
   output logic      [NB-1:0] pin_in
);
   logic [NB-1:0] lvl;
   logic [NB-1:0] last_q = '0;

   // Undriven and unpulled line shows the inverse of its last level
   assign lvl = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
              | (pin_oe_n & ~ext_en & (pin_pullup_en | ~last_q));
   // Blocked input buffer passes no level
   assign pin_in = lvl & pin_in_buf_en;

   always @(posedge clk) begin
      last_q <= lvl;
   end
endmodule : bgp_pin_model

// ===== dv/test_byte_wide_gpio_port.sv
// Self-checking testbench for the byte-wide GPIO port block
`timescale 1ns/1ps
module test_byte_wide_gpio_port;
   import bgp_pkg::*;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [55:0] pin_in, pin_out, pin_oe_n, pin_pullup_en, pin_in_buf_en, periph_in;
   logic [55:0] periph_out = '0;
   logic [55:0] periph_oe = '0;
   logic [55:0] ext_val = '0;
   logic [55:0] ext_en = '1;
   logic [7:0]  alt_m [7] = '{default: 8'h00};
   logic [7:0]  dir_m [7] = '{default: 8'h00};
   logic [7:0]  dout_m [7];
   logic [7:0]  wk_m [7] = '{default: 8'h00};
   logic [11:0] bad [8] = '{12'h008, 12'h048, 12'h000, 12'h020,
                            12'h014, 12'h0e0, 12'h042, 12'h100};
   logic [31:0] rd;
   int          fail_count = 0;
   int          checked = 0;

   always #2.5 clk = ~clk;

   bgp_port i_dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
      .pin_in_buf_en(pin_in_buf_en), .periph_out(periph_out),
      .periph_oe(periph_oe), .periph_in(periph_in));

   bgp_pin_model i_pins (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_pullup_en(pin_pullup_en), .pin_in_buf_en(pin_in_buf_en),
      .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

   // ------------------------------------------------------------
   // Checking and bus tasks
   // ------------------------------------------------------------
   task automatic report_and_stop();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic [55:0] got, input logic [55:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk_pin

   function automatic logic [11:0] adr(input int p, input logic [2:0] r);
      return 12'(p * 32) | {7'h0, r, 2'b00};
   endfunction : adr

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv, input logic exp_err);
      int n;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         fail_count++;
         report_and_stop();
      end else begin
         rdv = prdata;
         chk_reg({31'h0, pslverr}, {31'h0, exp_err});
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask : apb

   task automatic set_reg(input int p, input logic [2:0] r, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, adr(p, r), d, x, 1'b0);
      case (r)
         REG_ALT:  alt_m[p] = d[7:0];
         REG_DIR:  dir_m[p] = d[7:0];
         REG_DOUT: dout_m[p] = d[7:0];
         default:  wk_m[p] = d[7:0];
      endcase
   endtask : set_reg

   task automatic rd_chk(input int p, input logic [2:0] r, input logic [7:0] e);
      logic [31:0] x;
      apb(1'b0, adr(p, r), 32'h0, x, 1'b0);
      chk_reg(x, {24'h0, e});
   endtask : rd_chk

   task automatic check_all();
      logic [55:0] oe_e, out_e, pu_e, ib_e, lv, kn;
      logic [31:0] x;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 56; i++) begin
         ib_e[i]  = alt_m[i/8][i%8];
         out_e[i] = ib_e[i] ? periph_out[i] : dout_m[i/8][i%8];
         oe_e[i]  = ~(ib_e[i] ? periph_oe[i] : dir_m[i/8][i%8]);
         pu_e[i]  = ~ib_e[i] & wk_m[i/8][i%8] & ~dir_m[i/8][i%8];
         kn[i]    = ~oe_e[i] | ext_en[i] | pu_e[i];
         lv[i]    = ~oe_e[i] ? out_e[i] : (ext_en[i] ? ext_val[i] : 1'b1);
      end
      chk_pin(pin_out, out_e);
      chk_pin(pin_oe_n, oe_e);
      chk_pin(pin_pullup_en, pu_e);
      chk_pin(pin_in_buf_en, ib_e);
      chk_pin(periph_in & kn, ib_e & lv & kn);
      for (int p = 0; p < 7; p++) begin
         if (PORT_HAS_ALT[p]) begin
            rd_chk(p, REG_ALT, alt_m[p]);
         end
         rd_chk(p, REG_DIR, dir_m[p]);
         rd_chk(p, REG_DOUT, dout_m[p]);
         rd_chk(p, REG_WKPU, wk_m[p]);
         apb(1'b0, adr(p, REG_DIN), 32'h0, x, 1'b0);
         chk_reg(x & {24'h0, kn[8*p+:8]}, {24'h0, lv[8*p+:8] & kn[8*p+:8]});
      end
   endtask : check_all

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      void'($urandom(13603));
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      for (int p = 0; p < 7; p++) begin
         set_reg(p, REG_DOUT, $urandom);
      end
      check_all();
      for (int it = 0; it < 6; it++) begin
         for (int p = 0; p < 7; p++) begin
            if (PORT_HAS_ALT[p]) begin
               set_reg(p, REG_ALT, $urandom);
            end
            set_reg(p, REG_DIR, $urandom);
            set_reg(p, REG_DOUT, $urandom);
            set_reg(p, REG_WKPU, $urandom);
         end
         @(posedge clk);
         periph_out <= 56'({$urandom, $urandom});
         periph_oe  <= 56'({$urandom, $urandom});
         ext_val    <= 56'({$urandom, $urandom});
         ext_en     <= 56'({$urandom, $urandom});
         check_all();
      end
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, bad[k], 32'hff, rd, 1'b1);
      end
      apb(1'b0, 12'h0e0, 32'h0, rd, 1'b1);
      chk_reg(rd, 32'h0);
      check_all();
      set_reg(3, REG_ALT, 32'h0);
      set_reg(3, REG_DOUT, 32'h0);
      set_reg(3, REG_DIR, 32'hff);
      check_all();
      set_reg(3, REG_DIR, 32'h0);
      set_reg(3, REG_WKPU, 32'hff);
      check_all();
      @(posedge clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      for (int p = 0; p < 7; p++) begin
         alt_m[p] = 8'h00;
         dir_m[p] = 8'h00;
         wk_m[p]  = 8'h00;
      end
      check_all();
      report_and_stop();
   end
endmodule : test_byte_wide_gpio_port

// ===== rtl/bgp_pkg.sv
// Shared constants and types for the byte-wide GPIO port block
package bgp_pkg;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int              PORT_BITS    = 8;
   localparam int              NUM_PORTS    = 7;
   localparam logic [6:0]      PORT_HAS_ALT = 7'h7c;
   localparam int              SYNC_STAGES  = 2;

   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam int              ADDR_W       = 12;
   localparam int              DATA_W       = 32;
   localparam int              PORT_LSB     = 5;
   localparam int              PORT_W       = 3;
   localparam int              REG_LSB      = 2;
   localparam int              REG_W        = 3;
   localparam logic [REG_W-1:0] REG_ALT     = 3'h0;
   localparam logic [REG_W-1:0] REG_DIR     = 3'h1;
   localparam logic [REG_W-1:0] REG_DIN     = 3'h2;
   localparam logic [REG_W-1:0] REG_DOUT    = 3'h3;
   localparam logic [REG_W-1:0] REG_WKPU    = 3'h4;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [PORT_BITS-1:0] RST_ALT  = 8'h00;
   localparam logic [PORT_BITS-1:0] RST_DIR  = 8'h00;
   localparam logic [PORT_BITS-1:0] RST_WKPU = 8'h00;
   localparam logic [DATA_W-1:0]    RD_ZERO  = 32'h0000_0000;

   // ------------------------------------------------------------
   // Bus slave states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b00,
      BUS_SYNC = 2'b01,
      BUS_DONE = 2'b10
   } bgp_bus_t;

endpackage : bgp_pkg

// ===== rtl/bgp_port.sv
// APB-mapped bank of byte-wide general-purpose I/O ports
//
// Behaviour
// RQ1: Alternate-select 0 gives general mode: direction and output value drive pin.
// RQ2: General-mode input buffer is enabled only while input register is read.
// RQ3: Alternate-select 1 hands output and enable to peripheral; input always on.
// RQ4: Reset clears all alternate-select bits, pins start as general I/O.
// RQ5: Software sets alternate-select before enabling the peripheral function.
// RQ6: Direction 0 floats the output buffer; direction 1 enables it.
// RQ7: Reset clears all direction bits, every pin starts as input.
// RQ8: Pin input register returns present pin levels at any time; read-only.
// RQ9: Output value writes change driven level; reads return last value written.
// RQ10: Reset leaves output value register unchanged.
// RQ11: Pull-up select bit 1 selects weak pull-up, 0 deselects it.
// RQ12: Pull-up active only in general mode with floating output; never alternate.
// RQ13: Reset clears all pull-up select bits.
// RQ14: Open drain: output value 0, direction 1 drives low, 0 floats.
// RQ15: Register bit n affects only pin n of its own port.
// RQ16: Ports without alternate functions have no alternate-select register.
// RQ17: Up to seven ports of eight pins, byte-wide registers.
// RQ18: All port registers read/write except pin input register.
// RQ19: Pin levels pass a two-stage synchroniser before use.
//
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ps
module bgp_port #(
   parameter int         NP      = bgp_pkg::NUM_PORTS,
   parameter logic [6:0] HAS_ALT = bgp_pkg::PORT_HAS_ALT,
   parameter int         SYNC    = bgp_pkg::SYNC_STAGES
) (
   input  wire logic                                  clk,
   input  wire logic                                  reset_n,
   input  wire logic                                  psel,
   input  wire logic                                  penable,
   input  wire logic                                  pwrite,
   input  wire logic [bgp_pkg::ADDR_W-1:0]            paddr,
   input  wire logic [bgp_pkg::DATA_W-1:0]            pwdata,
   output logic      [bgp_pkg::DATA_W-1:0]            prdata,
   output logic                                       pready,
   output logic                                       pslverr,
   input  wire logic [NP*bgp_pkg::PORT_BITS-1:0]      pin_in,
   output logic      [NP*bgp_pkg::PORT_BITS-1:0]      pin_out,
   output logic      [NP*bgp_pkg::PORT_BITS-1:0]      pin_oe_n,
   output logic      [NP*bgp_pkg::PORT_BITS-1:0]      pin_pullup_en,
   output logic      [NP*bgp_pkg::PORT_BITS-1:0]      pin_in_buf_en,
   input  wire logic [NP*bgp_pkg::PORT_BITS-1:0]      periph_out,
   input  wire logic [NP*bgp_pkg::PORT_BITS-1:0]      periph_oe,
   output logic      [NP*bgp_pkg::PORT_BITS-1:0]      periph_in
);
   import bgp_pkg::*;

   localparam int              NB       = NP * PORT_BITS;
   localparam logic [2:0]      DIN_WAIT = 3'(SYNC);

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   logic [NP-1:0][PORT_BITS-1:0] alt_q;
   logic [NP-1:0][PORT_BITS-1:0] dir_q;
   logic [NP-1:0][PORT_BITS-1:0] dout_q;
   logic [NP-1:0][PORT_BITS-1:0] wkpu_q;
   logic [NP-1:0][PORT_BITS-1:0] din_arr;
   logic [NP-1:0][PORT_BITS-1:0] rd_mask;
   logic [NB-1:0]                din_sync;
   logic [NB-1:0]                alt_flat;
   logic [NB-1:0]                dir_flat;
   logic [NB-1:0]                dout_flat;
   logic [NB-1:0]                wkpu_flat;
   logic [NB-1:0]                rd_flat;

   // ------------------------------------------------------------
   // Bus slave state
   // ------------------------------------------------------------
   bgp_bus_t                     state_q;
   bgp_bus_t                     state_d;
   logic [2:0]                   cnt_q;
   logic [2:0]                   cnt_d;
   logic                         din_busy_q;
   logic                         din_busy_d;
   logic [DATA_W-1:0]            prdata_q;
   logic [DATA_W-1:0]            prdata_d;
   logic                         pready_q;
   logic                         pready_d;
   logic                         pslverr_q;
   logic                         pslverr_d;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire [PORT_W-1:0]    port_idx  = paddr[PORT_LSB +: PORT_W];
   wire [REG_W-1:0]     reg_sel   = paddr[REG_LSB +: REG_W];
   wire                 hi_zero   = (paddr[ADDR_W-1:PORT_LSB+PORT_W] == '0);
   wire                 lo_zero   = (paddr[REG_LSB-1:0] == '0);
   wire                 port_ok   = (port_idx < PORT_W'(NP));             // RQ17
   wire                 alt_here  = port_ok && HAS_ALT[port_idx];
   wire                 reg_ok    = (reg_sel == REG_ALT) ? alt_here        // RQ16
                                                         : (reg_sel <= REG_WKPU);
   wire                 acc_ok    = hi_zero && lo_zero && port_ok && reg_ok;
   wire                 ro_hit    = (reg_sel == REG_DIN) && pwrite;        // RQ18
   wire                 setup     = (state_q == BUS_IDLE) && psel && !penable;
   wire                 din_setup = setup && acc_ok && !pwrite && (reg_sel == REG_DIN);
   wire                 complete  = (state_q == BUS_DONE) && psel && penable;
   wire                 wr_ok     = complete && pwrite && acc_ok && !ro_hit;
   wire                 din_hold  = din_busy_q && psel && !complete;
   wire                 din_live  = din_setup || din_hold;
   wire [PORT_BITS-1:0] rd_byte   = (reg_sel == REG_ALT)  ? alt_q[port_idx]  :
                                    (reg_sel == REG_DIR)  ? dir_q[port_idx]  :
                                    (reg_sel == REG_DOUT) ? dout_q[port_idx] : // RQ9
                                    (reg_sel == REG_WKPU) ? wkpu_q[port_idx] :
                                                            din_arr[port_idx];
   wire [DATA_W-1:0]    rd_word   = acc_ok ? {{(DATA_W-PORT_BITS){1'b0}}, rd_byte} : RD_ZERO;

   // ------------------------------------------------------------
   // Per-port registers
   // ------------------------------------------------------------
   genvar p;
   generate
      for (p = 0; p < NP; p++) begin : g_port
         wire                  hit = wr_ok && (port_idx == PORT_W'(p));
         logic [PORT_BITS-1:0] dir_bits_q;
         logic [PORT_BITS-1:0] dout_bits_q;
         logic [PORT_BITS-1:0] wkpu_bits_q;

         if (HAS_ALT[p]) begin : g_alt
            logic [PORT_BITS-1:0] alt_bits_q;

            always_ff @(posedge clk or negedge reset_n) begin
               if (!reset_n) begin
                  alt_bits_q <= RST_ALT;                   // RQ4
               end else if (hit && reg_sel == REG_ALT) begin
                  alt_bits_q <= pwdata[PORT_BITS-1:0];
               end
            end
            assign alt_q[p] = alt_bits_q;
         end else begin : g_noalt
            assign alt_q[p] = RST_ALT;                     // RQ16
         end

         always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
               dir_bits_q  <= RST_DIR;                     // RQ7
               wkpu_bits_q <= RST_WKPU;                    // RQ13
            end else begin
               if (hit && reg_sel == REG_DIR) begin
                  dir_bits_q <= pwdata[PORT_BITS-1:0];
               end
               if (hit && reg_sel == REG_WKPU) begin
                  wkpu_bits_q <= pwdata[PORT_BITS-1:0];
               end
            end
         end

         // Kept through reset on purpose
         always_ff @(posedge clk) begin
            if (hit && reg_sel == REG_DOUT) begin
               dout_bits_q <= pwdata[PORT_BITS-1:0];       // RQ10
            end
         end

         assign dir_q[p]  = dir_bits_q;
         assign dout_q[p] = dout_bits_q;
         assign wkpu_q[p] = wkpu_bits_q;

         assign rd_mask[p] = {PORT_BITS{din_live && (port_idx == PORT_W'(p))}};
      end
   endgenerate

   assign alt_flat  = alt_q;
   assign dir_flat  = dir_q;
   assign dout_flat = dout_q;
   assign wkpu_flat = wkpu_q;
   assign rd_flat   = rd_mask;
   assign din_arr   = din_sync;

   // ------------------------------------------------------------
   // Input synchroniser
   // ------------------------------------------------------------
   bgp_sync #(
      .W      (NB),
      .STAGES (SYNC)
   ) u_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .d       (pin_in),
      .q       (din_sync)                                  // RQ19
   );

   // ------------------------------------------------------------
   // Pin control, bitwise so each bit drives only its own pin
   // ------------------------------------------------------------
   wire [NB-1:0] gp_flat   = ~alt_flat;
   wire [NB-1:0] out_d     = (alt_flat & periph_out) | (gp_flat & dout_flat);  // RQ1 RQ3 RQ15
   wire [NB-1:0] oe_n_d    = ~((alt_flat & periph_oe) | (gp_flat & dir_flat)); // RQ6 RQ14
   wire [NB-1:0] pullup_d  = gp_flat & wkpu_flat & ~dir_flat;                 // RQ11 RQ12
   wire [NB-1:0] inbuf_d   = alt_flat | (gp_flat & rd_flat);                  // RQ2 RQ3

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_out       <= '0;
         pin_oe_n      <= '1;
         pin_pullup_en <= '0;
         pin_in_buf_en <= '0;
      end else begin
         pin_out       <= out_d;
         pin_oe_n      <= oe_n_d;
         pin_pullup_en <= pullup_d;
         pin_in_buf_en <= inbuf_d;
      end
   end

   assign periph_in = din_sync;                            // RQ19

   // ------------------------------------------------------------
   // Bus slave sequencing
   // ------------------------------------------------------------
   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      din_busy_d = din_busy_q;
      prdata_d   = prdata_q;
      pready_d   = pready_q;
      pslverr_d  = pslverr_q;
      unique case (state_q)
         BUS_IDLE: begin
            if (setup) begin
               pslverr_d = !acc_ok || ro_hit;              // RQ18
               if (din_setup) begin
                  state_d    = BUS_SYNC;
                  cnt_d      = '0;
                  din_busy_d = 1'b1;
               end else begin
                  state_d  = BUS_DONE;
                  pready_d = 1'b1;
                  prdata_d = pwrite ? RD_ZERO : rd_word;
               end
            end
         end
         BUS_SYNC: begin
            if (!psel) begin
               state_d    = BUS_IDLE;
               din_busy_d = 1'b0;
            end else if (cnt_q == DIN_WAIT) begin
               state_d  = BUS_DONE;
               pready_d = 1'b1;
               prdata_d = rd_word;                         // RQ8
            end else begin
               cnt_d = cnt_q + 3'h1;
            end
         end
         BUS_DONE: begin
            if (complete || !psel) begin
               state_d    = BUS_IDLE;
               pready_d   = 1'b0;
               pslverr_d  = 1'b0;
               din_busy_d = 1'b0;
            end
         end
         default: begin
            state_d = BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q    <= BUS_IDLE;
         cnt_q      <= '0;
         din_busy_q <= 1'b0;
         prdata_q   <= RD_ZERO;
         pready_q   <= 1'b0;
         pslverr_q  <= 1'b0;
      end else begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         din_busy_q <= din_busy_d;
         prdata_q   <= prdata_d;
         pready_q   <= pready_d;
         pslverr_q  <= pslverr_d;
      end
   end

   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   logic [NB-1:0] noalt_mask;
   generate
      for (p = 0; p < NP; p++) begin : g_mask
         assign noalt_mask[p*PORT_BITS +: PORT_BITS] = {PORT_BITS{!HAS_ALT[p]}};
      end
   endgenerate

   sequence s_din_setup;
      din_setup;
   endsequence

   sequence s_din_wait;
      (!pready_q)[*3] ##1 pready_q;
   endsequence

   AST_RESET_CLEAR: assert property ($rose(reset_n) |->                  // RQ4
      (alt_flat == '0) && (dir_flat == '0) && (wkpu_flat == '0))
      else $error("control registers not cleared by reset");
   AST_DIR_AFTER_RESET: assert property ($rose(reset_n) |-> ##1 (pin_oe_n == '1)) // RQ7
      else $error("pin driven right after reset");
   AST_DIN_WAIT: assert property (s_din_setup |-> ##1 s_din_wait)       // RQ19
      else $error("input read did not wait for the synchroniser");
   AST_DIN_VALUE: assert property (s_din_setup ##1 s_din_wait |->       // RQ8
      prdata_q[PORT_BITS-1:0] == $past(din_arr[port_idx]))
      else $error("input read returned wrong level");
   AST_INBUF_GP: assert property (                                       // RQ2
      (pin_in_buf_en & ~$past(alt_flat) & ~$past(rd_flat)) == '0)
      else $error("general-mode input buffer open outside a read");
   AST_INBUF_ALT: assert property ((alt_flat != '0) |=>                  // RQ3
      ((pin_in_buf_en & $past(alt_flat)) == $past(alt_flat)))
      else $error("alternate pin input buffer closed");
   AST_PULL_ALT: assert property ((pin_pullup_en & $past(alt_flat | dir_flat)) == '0) // RQ12
      else $error("pull-up active on alternate or driven pin");
   AST_OPEN_DRAIN: assert property (                                     // RQ14
      (~pin_oe_n & pin_out & $past(gp_flat & ~dout_flat)) == '0)
      else $error("open-drain pin driven high");
   AST_DOUT_READBACK: assert property ((wr_ok && reg_sel == REG_DOUT) |=> // RQ9
      dout_q[$past(port_idx)] == $past(pwdata[PORT_BITS-1:0]))
      else $error("output value write not stored");
   AST_RO_ERROR: assert property ((setup && pwrite && reg_sel == REG_DIN) // RQ18
      |=> pslverr_q && pready_q)
      else $error("write to input register not flagged");
   AST_NO_ALT_BC: assert property ((alt_flat & noalt_mask) == '0)       // RQ16
      else $error("alternate mode on a port without alternates");
   AST_GP_DIR: assert property (                                         // RQ6
      ((pin_oe_n ^ ~$past(dir_flat)) & $past(gp_flat)) == '0)
      else $error("general-mode drive does not follow direction");
   AST_ALT_OUT: assert property (                                        // RQ3
      ((pin_out ^ $past(periph_out)) & $past(alt_flat)) == '0)
      else $error("alternate pin value not taken from peripheral");
   AST_ALT_OE: assert property (                                         // RQ3
      ((pin_oe_n ^ ~$past(periph_oe)) & $past(alt_flat)) == '0)
      else $error("alternate pin enable not taken from peripheral");

endmodule : bgp_port

// ===== rtl/bgp_sync.sv
// Multi-stage level synchroniser for pin inputs
`timescale 1ns/1ps
module bgp_sync #(
   parameter int W      = 8,
   parameter int STAGES = 2
) (
   input  wire logic         clk,
   input  wire logic         reset_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] stage_q [STAGES];

   // Each stage reads only the one before it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int k = 0; k < STAGES; k++) begin
            stage_q[k] <= '0;
         end
      end else begin
         stage_q[0] <= d;
         for (int k = 1; k < STAGES; k++) begin
            stage_q[k] <= stage_q[k-1];
         end
      end
   end

   assign q = stage_q[STAGES-1];

endmodule : bgp_sync
